// ### design/embp_defs.vh
// Constants for the external memory bus pin block.
// Assumes inclusion by bare name from design files; holds definitions only.
`ifndef EMBP_DEFS_VH
`define EMBP_DEFS_VH
`define EMBP_BOOT_HALF_BIT 28
`define EMBP_BOOT_UPPER_BASE 32'h10000000
`define EMBP_ADDR_RESET 28'h0000000
`define EMBP_WRITE_STROBE_CYCLES 4'h1
`define EMBP_ST_IDLE 3'h0
`define EMBP_ST_SETUP 3'h1
`define EMBP_ST_READ 3'h2
`define EMBP_ST_WRITE 3'h3
`define EMBP_ST_HOLD 3'h4
`define EMBP_AREA_BOOT 2'h0
`define EMBP_AREA_SRAM 2'h1
`define EMBP_AREA_IO 2'h2
`endif

// ### design/embp_lane_map.v
// Byte lane mapping between the internal word and the external data pins.
// Assumes byte-wide areas use the uppermost lane only; purely combinational.
`timescale 1ns/1ps
module embp_lane_map (
    // Request side
    input wire byte_wide,
    input wire [1:0] byte_sel,
    input wire [31:0] wdata,
    input wire [3:0] byte_en,
    // Pin side
    input wire [31:0] pin_rdata,
    output reg [31:0] lane_wdata,
    output reg [3:0] lane_en,
    output reg [31:0] rdata_aligned
);
    always @* begin
        lane_wdata = wdata;
        lane_en = byte_en;
        rdata_aligned = pin_rdata;
        if (byte_wide) begin
            // Byte areas carry the selected byte on the top lane.
            lane_wdata = {wdata[{byte_sel, 3'h0} +: 8], 24'h000000};
            lane_en = 4'h1;
            rdata_aligned = {24'h000000, pin_rdata[31:24]};
        end
    end
endmodule

// ### design/embp_bus.v
// External memory bus pin sequencer: address, data, check bits and strobes.
// Assumes a controller on ref_clk issues one request at a time and that
// check bits and the test check bit come from the error logic elsewhere.
//
// Functional notes
// - Idle address bus keeps last access address.
// - Drive data bus only during writes.
// - Byte-wide areas use top data lane only.
// - Low seven check lines carry word check bits.
// - Top check line shows test check bit seven.
// - Drive check lines only on protected writes.
// - Output enable low throughout read cycles.
// - Read indicator high during read cycles.
// - Ready low, once through the two-flop sync, ends I/O access next edge.
// - Write strobe pulses low during write cycles.
// - Boot select by address half at 0x10000000.
// - Read enable only for the bank read.
// - Bank select only for addressed bank.
// - Byte strobe zero covers data bits 31..24.
// - I/O select asserted for I/O area access.
// - Bus exception sampled with data flags error.
`timescale 1ns/1ps
`include "embp_defs.vh"
module embp_bus #(
    parameter SRAM_BANKS = 5,
    parameter [3:0] WAIT_CYCLES = 4'h1
) (
    // Clock, reset and enable
    input wire ref_clk,
    input wire reset_n,
    input wire clk_en,
    // Request from the memory controller
    input wire req_valid,
    output wire req_ready,
    input wire req_write,
    input wire [31:0] req_addr,
    input wire [1:0] req_area,
    input wire [2:0] req_bank,
    input wire req_byte_wide,
    input wire req_edac,
    input wire [3:0] req_byte_en,
    input wire [31:0] req_wdata,
    input wire [6:0] req_check_out,
    input wire test_check_bit7,
    // Completion to the memory controller
    output reg done,
    output reg [31:0] rdata,
    output reg [6:0] rcheck,
    output reg mem_error,
    // External pins
    output reg [27:0] addr_pins,
    input wire [31:0] data_in,
    output reg [31:0] data_out,
    output reg data_oe,
    input wire [7:0] check_bits_in,
    output reg [7:0] check_bits_out,
    output reg check_bits_oe,
    output reg output_enable_n,
    output reg read_cycle,
    output reg write_strobe_n,
    output reg [1:0] boot_mem_sel_n,
    output reg [SRAM_BANKS-1:0] sram_bank_read_enable_n,
    output reg [SRAM_BANKS-1:0] sram_bank_select_n,
    output reg [3:0] sram_byte_write_n,
    output reg io_area_select_n,
    input wire io_ready_n,
    input wire bus_exception_n
);
    localparam ST_IDLE = `EMBP_ST_IDLE;
    localparam ST_SETUP = `EMBP_ST_SETUP;
    localparam ST_READ = `EMBP_ST_READ;
    localparam ST_WRITE = `EMBP_ST_WRITE;
    localparam ST_HOLD = `EMBP_ST_HOLD;

    reg [2:0] state;
    reg [3:0] wait_cnt;
    reg acc_write;
    reg [1:0] acc_area;
    reg [2:0] acc_bank;
    reg acc_byte_wide;
    reg acc_edac;
    reg [1:0] acc_byte_sel;
    reg [3:0] acc_byte_en;
    reg [31:0] acc_wdata;
    reg [6:0] acc_check;
    reg [1:0] acc_boot_sel;

    // Pin inputs pass two flip-flops; only the second stage is read.
    reg [31:0] data_meta, data_sync;
    reg [7:0] check_meta, check_sync;
    reg ready_meta, ready_sync, exc_meta, exc_sync;

    wire [31:0] lane_wdata;
    wire [3:0] lane_en;
    wire [31:0] rdata_aligned;

    embp_lane_map u_lane (
        .byte_wide(acc_byte_wide),
        .byte_sel(acc_byte_sel),
        .wdata(acc_wdata),
        .byte_en(acc_byte_en),
        .pin_rdata(data_sync),
        .lane_wdata(lane_wdata),
        .lane_en(lane_en),
        .rdata_aligned(rdata_aligned)
    );

    // One-hot active-low select for a bank index.
    function [SRAM_BANKS-1:0] bank_dec_n;
        input [2:0] bank;
        integer i;
        begin
            for (i = 0; i < SRAM_BANKS; i = i + 1) begin
                bank_dec_n[i] = (bank != i[2:0]);
            end
        end
    endfunction

    assign req_ready = (state == ST_IDLE);

    wire active = (state == ST_READ) || (state == ST_WRITE);
    wire io_acc = (acc_area == `EMBP_AREA_IO);
    // Non-I/O accesses end on the wait count; I/O ones wait for ready.
    wire finish = io_acc ? !ready_sync : (wait_cnt == 4'h0);
    wire [31:0] boot_base = `EMBP_BOOT_UPPER_BASE;

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_meta <= 32'h00000000;
            data_sync <= 32'h00000000;
            check_meta <= 8'h00;
            check_sync <= 8'h00;
            ready_meta <= 1'b1;
            ready_sync <= 1'b1;
            exc_meta <= 1'b1;
            exc_sync <= 1'b1;
        end else if (clk_en) begin
            data_meta <= data_in;
            data_sync <= data_meta;
            check_meta <= check_bits_in;
            check_sync <= check_meta;
            ready_meta <= io_ready_n;
            ready_sync <= ready_meta;
            exc_meta <= bus_exception_n;
            exc_sync <= exc_meta;
        end
    end

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            wait_cnt <= 4'h0;
            acc_write <= 1'b0;
            acc_area <= `EMBP_AREA_BOOT;
            acc_bank <= 3'h0;
            acc_byte_wide <= 1'b0;
            acc_edac <= 1'b0;
            acc_byte_sel <= 2'h0;
            acc_byte_en <= 4'h0;
            acc_wdata <= 32'h00000000;
            acc_check <= 7'h00;
            acc_boot_sel <= 2'h3;
            addr_pins <= `EMBP_ADDR_RESET;
            done <= 1'b0;
            rdata <= 32'h00000000;
            rcheck <= 7'h00;
            mem_error <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            mem_error <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (req_valid) begin
                        // Address only changes here, so idle keeps the last one.
                        addr_pins <= req_addr[27:0];
                        acc_write <= req_write;
                        acc_area <= req_area;
                        acc_bank <= req_bank;
                        acc_byte_wide <= req_byte_wide;
                        acc_edac <= req_edac;
                        acc_byte_sel <= req_addr[1:0];
                        acc_byte_en <= req_byte_en;
                        acc_wdata <= req_wdata;
                        acc_check <= req_check_out;
                        acc_boot_sel <= (req_addr < boot_base) ? 2'h2 : 2'h1;
                        wait_cnt <= WAIT_CYCLES;
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    state <= acc_write ? ST_WRITE : ST_READ;
                end
                ST_READ, ST_WRITE: begin
                    if (wait_cnt != 4'h0) begin
                        wait_cnt <= wait_cnt - 4'h1;
                    end
                    if (finish) begin
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // The pin synchronisers lag two edges, so data and exception are
                    // taken here, where they still come from inside the strobe window.
                    // With WAIT_CYCLES of zero this capture would see pre-strobe data.
                    done <= 1'b1;
                    mem_error <= !exc_sync;
                    if (!acc_write) begin
                        rdata <= rdata_aligned;
                        rcheck <= check_sync[6:0];
                    end
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Pin strobes are registered so they cannot glitch on decode changes.
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_out <= 32'h00000000;
            data_oe <= 1'b0;
            check_bits_out <= 8'h00;
            check_bits_oe <= 1'b0;
            output_enable_n <= 1'b1;
            read_cycle <= 1'b0;
            write_strobe_n <= 1'b1;
            boot_mem_sel_n <= 2'h3;
            sram_bank_read_enable_n <= {SRAM_BANKS{1'b1}};
            sram_bank_select_n <= {SRAM_BANKS{1'b1}};
            sram_byte_write_n <= 4'hF;
            io_area_select_n <= 1'b1;
        end else if (clk_en) begin
            data_out <= lane_wdata;
            check_bits_out <= {test_check_bit7, acc_check};
            // Selects cover setup through access; idle holds all high.
            if ((state == ST_SETUP) || (active && !finish)) begin
                boot_mem_sel_n <= (acc_area == `EMBP_AREA_BOOT) ? acc_boot_sel : 2'h3;
                sram_bank_select_n <= (acc_area == `EMBP_AREA_SRAM) ?
                    bank_dec_n(acc_bank) : {SRAM_BANKS{1'b1}};
                io_area_select_n <= !io_acc;
                data_oe <= acc_write;
                check_bits_oe <= acc_write && acc_edac;
                read_cycle <= !acc_write;
                output_enable_n <= acc_write;
                sram_bank_read_enable_n <= (!acc_write && acc_area == `EMBP_AREA_SRAM) ?
                    bank_dec_n(acc_bank) : {SRAM_BANKS{1'b1}};
                // Strobes go low only once setup is done.
                write_strobe_n <= !(acc_write && active);
                sram_byte_write_n <= (acc_write && active && acc_area == `EMBP_AREA_SRAM) ?
                    ~lane_en : 4'hF;
            end else begin
                boot_mem_sel_n <= 2'h3;
                sram_bank_select_n <= {SRAM_BANKS{1'b1}};
                io_area_select_n <= 1'b1;
                data_oe <= 1'b0;
                check_bits_oe <= 1'b0;
                read_cycle <= 1'b0;
                output_enable_n <= 1'b1;
                sram_bank_read_enable_n <= {SRAM_BANKS{1'b1}};
                write_strobe_n <= 1'b1;
                sram_byte_write_n <= 4'hF;
            end
        end
    end
endmodule

// ### test/embp_bus_assertions.sv
// Concurrent checks on the external memory bus pins of embp_bus.
// Assumes one ref_clk domain with asynchronous active-low reset_n.
`timescale 1ns/1ps
module embp_bus_checker #(
    parameter SRAM_BANKS = 5
) (
    // Clock and reset
    input wire ref_clk,
    input wire reset_n,
    // Request side
    input wire req_valid,
    input wire req_ready,
    input wire done,
    input wire mem_error,
    input wire test_check_bit7,
    // Pins
    input wire [27:0] addr_pins,
    input wire data_oe,
    input wire [7:0] check_bits_out,
    input wire check_bits_oe,
    input wire output_enable_n,
    input wire read_cycle,
    input wire write_strobe_n,
    input wire [1:0] boot_mem_sel_n,
    input wire [SRAM_BANKS-1:0] sram_bank_read_enable_n,
    input wire [SRAM_BANKS-1:0] sram_bank_select_n,
    input wire [3:0] sram_byte_write_n,
    input wire io_area_select_n,
    input wire io_ready_n
);
    default clocking clk_def @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    idle_addr_a: assert property (req_ready && !req_valid |=> $stable(addr_pins))
        else $error("address moved while idle");
    write_drive_a: assert property (data_oe |-> output_enable_n && !read_cycle)
        else $error("data driven outside a write");
    check_drive_a: assert property (check_bits_oe |->
        data_oe && check_bits_out[7] == test_check_bit7)
        else $error("check lines driven wrongly");
    read_pair_a: assert property (!output_enable_n |-> read_cycle && write_strobe_n)
        else $error("read indicator disagrees with output enable");
    strobe_write_a: assert property (!write_strobe_n || sram_byte_write_n != 4'hF |-> data_oe)
        else $error("write strobe without driven data");
    boot_half_a: assert property (!boot_mem_sel_n[0] |-> boot_mem_sel_n[1])
        else $error("both boot selects low");
    one_bank_a: assert property ($onehot0(~sram_bank_select_n)
        && (~sram_bank_read_enable_n & sram_bank_select_n) == 0)
        else $error("bank select or read enable not exclusive");
    io_alone_a: assert property (!io_area_select_n |-> &boot_mem_sel_n && &sram_bank_select_n)
        else $error("io select together with a memory select");
    io_finish_a: assert property ($fell(io_ready_n) && !io_area_select_n |-> ##[1:4] done)
        else $error("io access not ended after ready");
    err_done_a: assert property (mem_error |-> done)
        else $error("memory error without completion");
    idle_quiet_a: assert property (req_ready && $past(req_ready) |-> &{boot_mem_sel_n,
        sram_bank_select_n, sram_bank_read_enable_n, sram_byte_write_n, io_area_select_n,
        write_strobe_n, output_enable_n})
        else $error("select or strobe low while idle");
    cover property (done && !mem_error);
    cover property (mem_error);
    cover property (!io_area_select_n && !io_ready_n);
    cover property (!write_strobe_n && sram_byte_write_n != 4'hF);
endmodule
bind embp_bus embp_bus_checker #(.SRAM_BANKS(SRAM_BANKS)) u_embp_bus_checker (.*);

// ### test/embp_mem_model.sv
// Model of the boot memory, static RAM and I/O devices on the bus pins.
// Assumes the bench commands a slow ready and a bus exception on purpose.
`timescale 1ns/1ps
module embp_mem_model (
    // Clock and commanded behaviour
    input wire ref_clk,
    input wire fault,
    input wire [3:0] io_delay,
    // Pins from the controller
    input wire [27:0] addr_pins,
    input wire [31:0] data_out,
    input wire [7:0] check_bits_out,
    input wire check_bits_oe,
    input wire output_enable_n,
    input wire write_strobe_n,
    input wire [3:0] sram_byte_write_n,
    input wire [4:0] sram_bank_select_n,
    input wire io_area_select_n,
    // Pins back to the controller
    output logic [31:0] data_in,
    output logic [7:0] check_bits_in,
    output logic io_ready_n,
    output logic bus_exception_n
);
    logic [31:0] mem [0:15];
    logic [6:0] cbm [0:15];
    logic [31:0] last = 32'h0;
    logic [3:0] wait_cnt = 4'h0;
    wire [3:0] idx = addr_pins[5:2];
    // A released data bus toggles every cycle so a stale sample never matches.
    assign data_in = !output_enable_n ? mem[idx] : ~last;
    assign check_bits_in = !output_enable_n ? {1'b1, cbm[idx]} : 8'hFF;
    assign bus_exception_n = !(fault && !output_enable_n);
    assign io_ready_n = !(!io_area_select_n && wait_cnt >= io_delay);
    always @(posedge ref_clk) begin
        last <= data_in;
        wait_cnt <= io_area_select_n ? 4'h0 : wait_cnt + 4'h1;
        if (!write_strobe_n) begin
            for (int i = 0; i < 4; i++)
                if (!sram_byte_write_n[i] || &sram_bank_select_n)
                    mem[idx][31-8*i -: 8] <= data_out[31-8*i -: 8];
            cbm[idx] <= check_bits_oe ? check_bits_out[6:0] : 7'h7F;
        end
    end
endmodule

// ### test/embp_bus_bench.sv
// Self-checking bench for embp_bus with the memory model on its pins.
// Assumes accesses are issued one at a time, 1 ns after the rising edge.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", what, exp, got); end end
module embp_bus_bench;
    logic ref_clk = 0, reset_n = 0, clk_en = 1, req_valid = 0, req_write = 0, fault = 0;
    logic req_byte_wide = 0, req_edac = 0, test_check_bit7 = 0;
    logic [31:0] req_addr = 0, req_wdata = 0;
    logic [1:0] req_area = 0;
    logic [2:0] req_bank = 0;
    logic [3:0] req_byte_en = 0, io_delay = 0;
    logic [6:0] req_check_out = 0;
    wire req_ready, done, mem_error, data_oe, check_bits_oe, output_enable_n, read_cycle;
    wire write_strobe_n, io_area_select_n, io_ready_n, bus_exception_n;
    wire [31:0] rdata, data_in, data_out;
    wire [6:0] rcheck;
    wire [27:0] addr_pins;
    wire [7:0] check_bits_in, check_bits_out;
    wire [1:0] boot_mem_sel_n;
    wire [4:0] sram_bank_read_enable_n, sram_bank_select_n;
    wire [3:0] sram_byte_write_n;
    int mismatches = 0, checks = 0, seed = 89;
    logic [41:0] notes[$];
    logic [41:0] note;
    logic [31:0] shadow [0:15];
    logic [6:0] cshadow [0:15];
    logic [7:0] seen;
    logic [4:0] seen_oe;
    always #12.5 ref_clk = ~ref_clk;
    embp_bus u_embp_bus (.*);
    embp_mem_model u_embp_mem_model (.*);
    task automatic finish_test;
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        while (req_ready !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            if (++n > 50) begin
                mismatches++;
                finish_test();
            end
        end
    endtask
    task automatic acc(input logic w, input logic [1:0] area, input logic [31:0] a,
        input logic [2:0] bank, input logic bw, input logic [3:0] be, input logic edac,
        input logic err);
        logic [3:0] i;
        logic [7:0] sel;
        i = a[5:2];
        sel = area == 2'h0 ? (a < 32'h10000000 ? 8'h01 : 8'h02) :
            area == 2'h2 ? 8'h80 : 8'h04 << bank;
        wait_ready();
        {req_write, req_area, req_addr, req_bank} = {w, area, a, bank};
        {req_byte_wide, req_byte_en, req_edac} = {bw, be, edac};
        req_wdata = $random(seed);
        req_check_out = $random(seed);
        test_check_bit7 = $random(seed);
        if (w && bw)
            shadow[i][31:24] = req_wdata[8*a[1:0] +: 8];
        else if (w)
            for (int k = 0; k < 4; k++)
                if (be[k])
                    shadow[i][31-8*k -: 8] = req_wdata[31-8*k -: 8];
        if (w)
            cshadow[i] = edac ? req_check_out : 7'h7F;
        notes.push_back({bw, !w, err, cshadow[i], shadow[i]});
        fault = err;
        seen = 0;
        seen_oe = 0;
        req_valid = 1;
        @(posedge ref_clk);
        #1 req_valid = 0;
        wait_ready();
        fault = 0;
        `CHK("selects", sel, seen)
        `CHK("read enables", (!w && area == 2'h1) ? 5'h01 << bank : 5'h00, seen_oe)
    endtask
    always @(negedge ref_clk) begin
        seen |= {~io_area_select_n, ~sram_bank_select_n, ~boot_mem_sel_n};
        seen_oe |= ~sram_bank_read_enable_n;
        if (done === 1'b1 && notes.size() == 0)
            mismatches++;
        else if (done === 1'b1) begin
            note = notes.pop_front();
            `CHK("error", note[39], mem_error)
            if (note[40] && note[41])
                `CHK("byte", note[31:24], rdata[7:0])
            else if (note[40]) begin
                `CHK("rdata", note[31:0], rdata)
                `CHK("rcheck", note[38:32], rcheck)
            end
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 reset_n = 1;
        for (int b = 0; b < 5; b++)
            acc(1, 1, 4 * b, b, 0, 4'hF, b[0], 0);
        for (int b = 0; b < 5; b++)
            acc(0, 1, 4 * b, b, 0, 4'hF, b[0], 0);
        acc(1, 1, 32'h4, 1, 0, 4'h1, 1, 0);
        acc(0, 1, 32'h4, 1, 0, 4'hF, 1, 0);
        acc(1, 1, 32'h6, 2, 1, 4'hF, 0, 0);
        acc(0, 1, 32'h4, 2, 0, 4'hF, 0, 0);
        acc(0, 1, 32'h7, 2, 1, 4'hF, 0, 0);
        acc(1, 0, 32'h20, 0, 0, 4'hF, 1, 0);
        acc(0, 0, 32'h20, 0, 0, 4'hF, 1, 0);
        acc(0, 0, 32'h10000020, 0, 0, 4'hF, 1, 0);
        io_delay = 4'h3;
        acc(1, 2, 32'h30, 0, 0, 4'hF, 0, 0);
        acc(0, 2, 32'h30, 0, 0, 4'hF, 0, 0);
        acc(0, 1, 32'h8, 2, 0, 4'hF, 0, 1);
        finish_test();
    end
endmodule
